//--- rtl/egod_top.sv
// Electronic gear scaler with gear-range check and derated overload detection
// Assumes an AXI4-Lite master on aclk and reference pulse pins from a host
// What this block does
// - Each reference pulse is scaled by the gear into feedback pulses
// - Gear ratio equals numerator register over denominator register
// - Ratio below 0.001 or above 64000 raises parameter error
// - With multiplication enabled each pulse counts n reference units
// - Derating 10 to 100 percent, default 100, used after restart
// - Lower derating lowers the threshold so the alarm comes earlier
// - Warning at warning-level percent of alarm heat, default 20
`timescale 1ns/10ps
`include "egod_defines.svh"
module egod_top #(
  parameter logic [31:0] HEAT_LIMIT = `EGOD_HEAT_LIMIT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire egod_pkg::egod_axil_req_t s_req,
  output egod_pkg::egod_axil_rsp_t s_rsp,
  input wire logic ref_pulse,
  input wire logic ref_dir,
  input wire logic [15:0] load_current,
  output egod_pkg::egod_status_t status
);
  import egod_pkg::*;
  // Heat adds up to a full current step past the limit, so leave headroom
  if (HEAT_LIMIT == 32'h0 || HEAT_LIMIT > `EGOD_HEAT_MAX) begin : g_limit_check
    $error("HEAT_LIMIT out of range");
  end
  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  logic aw_held, w_held, bvalid, rvalid;
  logic [7:0] aw_addr;
  logic [31:0] w_data, rdata;
  logic [3:0] w_strb;
  logic [1:0] bresp, rresp;
  logic [31:0] num, den, heat;
  logic [15:0] derate;
  logic [7:0] warn_lvl;
  logic [8:0] mult;
  logic restart;
  logic next_aw_held, next_w_held, next_bvalid, next_rvalid, next_restart;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data, next_rdata, next_num, next_den;
  logic [3:0] next_w_strb;
  logic [1:0] next_bresp, next_rresp;
  logic [15:0] next_derate;
  logic [7:0] next_warn_lvl;
  logic [8:0] next_mult;
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction
  always_comb begin
    logic [31:0] m;
    m = 32'h0;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_num = num;
    next_den = den;
    next_derate = derate;
    next_warn_lvl = warn_lvl;
    next_mult = mult;
    next_restart = 1'b0;
    if (s_req.awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_req.awaddr;
    end
    if (s_req.wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_req.wdata;
      next_w_strb = s_req.wstrb;
    end
    if (bvalid && s_req.bready) next_bvalid = 1'b0;
    if (aw_held && w_held && !bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `EGOD_RESP_OK;
      case (aw_addr)
        `EGOD_OFF_NUM: next_num = merge(num, w_data, w_strb);
        `EGOD_OFF_DEN: next_den = merge(den, w_data, w_strb);
        `EGOD_OFF_DERATE: begin
          m = merge({16'h0, derate}, w_data, w_strb);
          next_derate = m[15:0];
        end
        `EGOD_OFF_WARN: begin
          m = merge({24'h0, warn_lvl}, w_data, w_strb);
          next_warn_lvl = m[7:0];
        end
        `EGOD_OFF_MULT: begin
          m = merge({23'h0, mult}, w_data, w_strb);
          next_mult = m[8:0];
        end
        `EGOD_OFF_CTRL: next_restart = w_strb[0] & w_data[0];
        default: next_bresp = `EGOD_RESP_ERR;
      endcase
    end
    if (rvalid && s_req.rready) next_rvalid = 1'b0;
    if (s_req.arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = `EGOD_RESP_OK;
      case (s_req.araddr)
        `EGOD_OFF_NUM: next_rdata = num;
        `EGOD_OFF_DEN: next_rdata = den;
        `EGOD_OFF_DERATE: next_rdata = {16'h0, derate};
        `EGOD_OFF_WARN: next_rdata = {24'h0, warn_lvl};
        `EGOD_OFF_MULT: next_rdata = {23'h0, mult};
        `EGOD_OFF_CTRL: next_rdata = 32'h0;
        `EGOD_OFF_STAT: next_rdata = {29'h0, status.ovl_alarm, status.ovl_warn,
                                      status.param_err};
        `EGOD_OFF_HEAT: next_rdata = heat;
        default: begin
          next_rdata = 32'h0;
          next_rresp = `EGOD_RESP_ERR;
        end
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `EGOD_RESP_OK;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `EGOD_RESP_OK;
      num <= `EGOD_RST_NUM;
      den <= `EGOD_RST_DEN;
      derate <= `EGOD_RST_DERATE;
      warn_lvl <= `EGOD_RST_WARN;
      mult <= `EGOD_RST_MULT;
      restart <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      num <= next_num;
      den <= next_den;
      derate <= next_derate;
      warn_lvl <= next_warn_lvl;
      mult <= next_mult;
      restart <= next_restart;
    end
  end
  assign s_rsp = '{awready: !aw_held, wready: !w_held, bvalid: bvalid, bresp: bresp,
                   arready: !rvalid, rvalid: rvalid, rdata: rdata, rresp: rresp};
  ////////////////////////////////////////////////////////////////////////////
  // Active settings, loaded at reset and on restart
  logic [31:0] act_num, act_den;
  logic [15:0] act_derate;
  logic [7:0] act_n;
  logic param_err, next_param_err;
  logic [31:0] next_act_num, next_act_den;
  logic [15:0] next_act_derate;
  logic [7:0] next_act_n;
  always_comb begin
    logic [63:0] lo_prod, hi_prod;
    lo_prod = 64'(num) * `EGOD_RATIO_MIN_DIV;
    hi_prod = 64'(den) * `EGOD_RATIO_MAX;
    next_act_num = act_num;
    next_act_den = act_den;
    next_act_derate = act_derate;
    next_act_n = act_n;
    next_param_err = param_err;
    if (restart) begin
      next_act_num = num;
      next_act_den = den;
      next_act_derate = derate;
      next_act_n = mult[8] ? mult[7:0] : 8'h01;
      next_param_err = (num == 32'h0) || (num > `EGOD_GEAR_MAX) || (den == 32'h0) ||
                       (den > `EGOD_GEAR_MAX) || (lo_prod < 64'(den)) ||
                       (64'(num) > hi_prod) || (derate < `EGOD_DERATE_MIN) ||
                       (derate > `EGOD_PCT_FULL) || (mult[8] && mult[7:0] == 8'h0);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_num <= `EGOD_RST_NUM;
      act_den <= `EGOD_RST_DEN;
      act_derate <= `EGOD_RST_DERATE;
      act_n <= 8'(`EGOD_RST_MULT);
      param_err <= 1'b0;
    end else begin
      act_num <= next_act_num;
      act_den <= next_act_den;
      act_derate <= next_act_derate;
      act_n <= next_act_n;
      param_err <= next_param_err;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Gear scaler: one feedback pulse per cycle, remainder carried
  logic [1:0] pulse_sync, dir_sync;
  logic pulse_last, fb_up, fb_down;
  logic signed [63:0] acc;
  logic next_pulse_last, next_fb_up, next_fb_down;
  logic signed [63:0] next_acc;
  always_comb begin
    logic signed [63:0] step, d;
    step = $signed(64'(act_num) * 64'(act_n));
    d = $signed(64'(act_den));
    next_pulse_last = pulse_sync[1];
    next_acc = acc;
    next_fb_up = 1'b0;
    next_fb_down = 1'b0;
    if (restart) begin
      next_acc = 64'sh0;
    end else if (!param_err) begin
      if (acc >= d) begin
        next_acc = acc - d;
        next_fb_up = 1'b1;
      end else if (acc <= -d) begin
        next_acc = acc + d;
        next_fb_down = 1'b1;
      end
      if (pulse_sync[1] && !pulse_last) next_acc = dir_sync[1] ? next_acc - step
                                                               : next_acc + step;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_sync <= 2'h0;
      dir_sync <= 2'h0;
      pulse_last <= 1'b0;
      acc <= 64'sh0;
      fb_up <= 1'b0;
      fb_down <= 1'b0;
    end else begin
      pulse_sync <= {pulse_sync[0], ref_pulse};
      dir_sync <= {dir_sync[0], ref_dir};
      pulse_last <= next_pulse_last;
      acc <= next_acc;
      fb_up <= next_fb_up;
      fb_down <= next_fb_down;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Overload heat integrator
  logic warn, alarm, next_warn, next_alarm;
  logic [31:0] next_heat;
  always_comb begin
    logic [47:0] lim_w, heat_w;
    lim_w = 48'(HEAT_LIMIT) * 48'(warn_lvl);
    heat_w = 48'(heat) * 48'(`EGOD_PCT_FULL);
    next_heat = heat;
    if (load_current > act_derate) begin
      if (heat < HEAT_LIMIT) next_heat = heat + 32'(load_current - act_derate);
    end else if (heat != 32'h0) begin
      next_heat = heat - 32'h1;
    end
    // Overload in the restart cycle still sets the alarm
    next_alarm = (heat >= HEAT_LIMIT) || (alarm && !restart);
    next_warn = heat_w >= lim_w;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      heat <= 32'h0;
      alarm <= 1'b0;
      warn <= 1'b0;
    end else begin
      heat <= next_heat;
      alarm <= next_alarm;
      warn <= next_warn;
    end
  end
  assign status = '{fb_up: fb_up, fb_down: fb_down, param_err: param_err,
                    ovl_warn: warn, ovl_alarm: alarm};
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  fb_up_cause_a: assert property (fb_up |-> $past(acc) >= $signed(64'(act_den)) &&
    !$past(param_err)) else $error("up pulse without credit");
  fb_err_quiet_a: assert property (param_err && !restart |=> !fb_up && !fb_down)
    else $error("pulse during gear error");
  ratio_high_a: assert property (restart && (64'(num) > 64'(den) * `EGOD_RATIO_MAX)
    |=> param_err) else $error("high ratio not flagged");
  ratio_low_a: assert property (restart && (64'(num) * `EGOD_RATIO_MIN_DIV < 64'(den))
    |=> param_err) else $error("low ratio not flagged");
  num_after_restart_a: assert property (!restart |=> $stable(act_num) && $stable(act_den)
    && $stable(act_derate)) else $error("setting used before restart");
  mult_step_a: assert property (restart && mult[8] |=> act_n == $past(mult[7:0]))
    else $error("multiplier not applied");
  acc_bound_a: assert property (!param_err && !restart && pulse_sync[1] == pulse_last
    && acc < $signed(64'(act_den)) && acc > -$signed(64'(act_den)) |=> $stable(acc))
    else $error("remainder lost");
  heat_rise_a: assert property (load_current > act_derate && heat < HEAT_LIMIT
    |=> heat > $past(heat)) else $error("heat not rising over threshold");
  alarm_set_a: assert property (heat >= HEAT_LIMIT && !restart |=> alarm)
    else $error("alarm missed");
  warn_level_a: assert property (warn |-> 48'($past(heat)) * 48'(`EGOD_PCT_FULL) >=
    48'(HEAT_LIMIT) * 48'($past(warn_lvl))) else $error("early warning");
  cov_up_c: cover property (fb_up ##1 fb_up);
  cov_down_c: cover property (fb_down);
  cov_err_c: cover property (restart ##1 param_err);
  cov_alarm_c: cover property (warn ##[1:1000] alarm);
endmodule // egod_top

//--- rtl/egod_defines.svh
// Offsets, reset values and limits for the electronic gear and overload block
// Included by the top module and by the test bench
`ifndef EGOD_DEFINES_SVH
`define EGOD_DEFINES_SVH
`define EGOD_OFF_NUM 8'h00
`define EGOD_OFF_DEN 8'h04
`define EGOD_OFF_DERATE 8'h08
`define EGOD_OFF_WARN 8'h0C
`define EGOD_OFF_MULT 8'h10
`define EGOD_OFF_CTRL 8'h14
`define EGOD_OFF_STAT 8'h18
`define EGOD_OFF_HEAT 8'h1C
`define EGOD_RST_NUM 32'h0000_0040
`define EGOD_RST_DEN 32'h0000_0001
`define EGOD_RST_DERATE 16'h0064
`define EGOD_RST_WARN 8'h14
`define EGOD_RST_MULT 9'h001
`define EGOD_GEAR_MAX 32'h4000_0000
`define EGOD_HEAT_LIMIT 32'h000F_4240
`define EGOD_HEAT_MAX 32'hFFFF_0000
`define EGOD_RATIO_MIN_DIV 64'h0000_0000_0000_03E8
`define EGOD_RATIO_MAX 64'h0000_0000_0000_FA00
`define EGOD_DERATE_MIN 16'h000A
`define EGOD_PCT_FULL 16'h0064
`define EGOD_RESP_OK 2'h0
`define EGOD_RESP_ERR 2'h2
`endif

//--- rtl/egod_pkg.sv
// Types shared by the electronic gear and overload block
// Assumes egod_defines.svh is on the include path
package egod_pkg;
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } egod_axil_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } egod_axil_rsp_t;
  typedef struct packed {
    logic fb_up;
    logic fb_down;
    logic param_err;
    logic ovl_warn;
    logic ovl_alarm;
  } egod_status_t;
endpackage

//--- verif/egod_pulse_host.sv
// Host model: emits reference pulse trains on request
// Assumes the bench starts a train with a one-cycle go
`timescale 1ns/10ps
module egod_pulse_host (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic [7:0] count,
  input wire logic dir,
  input wire logic [3:0] gap,
  output logic ref_pulse,
  output logic ref_dir,
  output logic busy
);
  logic [7:0] left;
  logic [4:0] tmr;
  assign busy = (left != 8'h00);
  // Direction settles before the first edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      ref_pulse <= 1'b0;
      ref_dir <= 1'b0;
      left <= 8'h00;
      tmr <= 5'h00;
    end else if (left == 8'h00) begin
      ref_pulse <= 1'b0;
      if (go) begin
        left <= count;
        ref_dir <= dir;
        tmr <= 5'h02;
      end
    end else if (tmr != 5'h00) begin
      tmr <= tmr - 5'h01;
    end else if (!ref_pulse) begin
      ref_pulse <= 1'b1;
      tmr <= 5'h02;
    end else begin
      ref_pulse <= 1'b0;
      tmr <= {1'b0, gap} + 5'h02;
      left <= left - 8'h01;
    end
  end
endmodule // egod_pulse_host

//--- verif/egod_top_test.sv
// Self-checking bench: registers, gear scaling, range check, overload
// Assumes egod_defines.svh on the include path
`timescale 1ns/10ps
`include "egod_defines.svh"
`define CHK(w, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; $display("wrong value %s expected %0h seen %0h", w, e, g); end end
module egod_top_test;
  import egod_pkg::*;
  logic aclk;
  logic aresetn;
  egod_axil_req_t req;
  egod_axil_rsp_t rsp;
  logic ref_pulse;
  logic ref_dir;
  logic [15:0] load_current;
  egod_status_t status;
  logic go;
  logic [7:0] count;
  logic dir;
  logic [3:0] gap;
  logic busy;
  int n_errors;
  int check_count;
  int seed;
  int n_up;
  int n_down;
  int tw1;
  int ta1;
  int tw2;
  int ta2;
  logic [31:0] rd;
  logic [1:0] rs;
  localparam logic [31:0] LN [10] = '{1, 1, 64000, 64001, 1, 1, 1, 0, 32'h4000_0000, 32'h4000_0001};
  localparam logic [31:0] LD [10] = '{1000, 1001, 1, 1, 1, 1, 1, 1, 32'h4000_0000, 32'h4000_0001};
  localparam logic [15:0] LR [10] = '{100, 100, 100, 100, 10, 9, 101, 100, 100, 100};
  localparam logic LE [10] = '{0, 1, 0, 1, 0, 1, 1, 1, 0, 1};
  egod_top #(.HEAT_LIMIT(32'd200)) dut (.aclk(aclk), .aresetn(aresetn), .s_req(req),
    .s_rsp(rsp), .ref_pulse(ref_pulse), .ref_dir(ref_dir), .load_current(load_current),
    .status(status));
  egod_pulse_host host (.aclk(aclk), .aresetn(aresetn), .go(go), .count(count), .dir(dir),
    .gap(gap), .ref_pulse(ref_pulse), .ref_dir(ref_dir), .busy(busy));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (status.fb_up === 1'b1) n_up <= n_up + 1;
    if (status.fb_down === 1'b1) n_down <= n_down + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic int exp_fb(input int np, input int nm, input int dn);
    return (np * nm) / dn;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta;
    logic tw;
    logic da;
    logic dw;
    da = 1'b0;
    dw = 1'b0;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge aclk);
      ta = req.awvalid && rsp.awready;
      tw = req.wvalid && rsp.wready;
      @(posedge aclk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end
    do begin
      @(negedge aclk);
      ta = rsp.bvalid;
      rs = rsp.bresp;
      @(posedge aclk);
    end while (!ta);
    req.bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rdr(input logic [7:0] a);
    logic t;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(negedge aclk);
      t = rsp.arready;
      @(posedge aclk);
    end while (!t);
    req.arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      t = rsp.rvalid;
      rd = rsp.rdata;
      rs = rsp.rresp;
      @(posedge aclk);
    end while (!t);
    req.rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic setup(input logic [31:0] nm, input logic [31:0] dn, input logic [15:0] dr,
                       input logic [8:0] ml);
    wr(`EGOD_OFF_NUM, nm);
    wr(`EGOD_OFF_DEN, dn);
    wr(`EGOD_OFF_DERATE, {16'h0000, dr});
    wr(`EGOD_OFF_MULT, {23'h0, ml});
    wr(`EGOD_OFF_CTRL, 32'h0000_0001);
    repeat (2) @(posedge aclk);
  endtask
  task automatic pulses(input logic [7:0] n, input logic d, input int e);
    n_up = 0;
    n_down = 0;
    count <= n;
    dir <= d;
    gap <= 4'($random(seed) & 3);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
    while (busy) @(posedge aclk);
    repeat (300) @(posedge aclk);
    `CHK("fb_up", d ? 0 : e, n_up)
    `CHK("fb_down", d ? e : 0, n_down)
  endtask
  task automatic ovl(input logic [15:0] dr, output int tw, output int ta);
    setup(32'h0000_0040, 32'h0000_0001, dr, 9'h001);
    tw = 0;
    ta = 0;
    load_current <= 16'h0066;
    for (int i = 1; i < 300; i++) begin
      @(negedge aclk);
      if (status.ovl_warn === 1'b1 && tw == 0) tw = i;
      if (status.ovl_alarm === 1'b1 && ta == 0) ta = i;
    end
    @(posedge aclk);
    load_current <= 16'h0000;
    repeat (400) @(posedge aclk);
    `CHK("alarm held", 1'b1, status.ovl_alarm)
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_errors++;
    summarize();
  end
  initial begin
    int nm;
    int dn;
    int np;
    seed = 13;
    n_errors = 0;
    check_count = 0;
    aresetn = 1'b0;
    req = '0;
    load_current = 16'h0000;
    go = 1'b0;
    count = 8'h00;
    dir = 1'b0;
    gap = 4'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(`EGOD_OFF_NUM);
    `CHK("num reset", 32'h0000_0040, rd)
    rdr(`EGOD_OFF_DEN);
    `CHK("den reset", 32'h0000_0001, rd)
    rdr(`EGOD_OFF_DERATE);
    `CHK("derate reset", 32'h0000_0064, rd)
    rdr(`EGOD_OFF_WARN);
    `CHK("warn reset", 32'h0000_0014, rd)
    wr(`EGOD_OFF_NUM, 32'h0000_0003);
    rdr(`EGOD_OFF_NUM);
    `CHK("num rw", 32'h0000_0003, rd)
    pulses(8'h01, 1'b0, 64);
    rdr(8'h20);
    `CHK("unmapped rresp", 2'h2, rs)
    wr(8'h24, 32'h0000_0001);
    `CHK("unmapped bresp", 2'h2, rs)
    // Random gears, remainder carried across pulses
    for (int i = 0; i < 5; i++) begin
      nm = 1 + ($unsigned($random(seed)) % 9);
      dn = 1 + ($unsigned($random(seed)) % 9);
      np = 1 + ($unsigned($random(seed)) % 20);
      setup(nm, dn, 16'h0064, 9'h001);
      pulses(8'(np), 1'($random(seed)), exp_fb(np, nm, dn));
    end
    setup(1, 1, 16'h0064, 9'h001);
    pulses(8'h0A, 1'b0, 10);
    setup(2, 3, 16'h0064, 9'h103);
    pulses(8'h05, 1'b1, 10);
    setup(2, 3, 16'h0064, 9'h003);
    pulses(8'h05, 1'b0, 3);
    for (int i = 0; i < 10; i++) begin
      setup(LN[i], LD[i], LR[i], 9'h001);
      `CHK("param_err", LE[i], status.param_err)
    end
    pulses(8'h03, 1'b0, 0);
    ovl(16'h0064, tw1, ta1);
    `CHK("warn to alarm", 80, ta1 - tw1)
    rdr(`EGOD_OFF_STAT);
    `CHK("status alarm", 32'h0000_0004, rd)
    rdr(`EGOD_OFF_HEAT);
    `CHK("heat drained", 32'h0000_0000, rd)
    ovl(16'h0032, tw2, ta2);
    `CHK("derated alarm", 96, ta1 - ta2)
    wr(`EGOD_OFF_WARN, 32'h0000_0032);
    rdr(`EGOD_OFF_WARN);
    `CHK("warn level rw", 32'h0000_0032, rd)
    ovl(16'h0064, tw2, ta2);
    `CHK("warn at half", 50, ta2 - tw2)
    summarize();
  end
endmodule // egod_top_test
